//--- inc/plk_pkg.sv
// Register map, field layout, reset values and carrier types of the PLL lock block
package plk_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses on the serial-port CSR path
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_LPF = 8'h00;
    localparam logic [7:0] ADDR_P3 = 8'h01;
    localparam logic [7:0] ADDR_LCK_LO = 8'h02;
    localparam logic [7:0] ADDR_LCK_HI = 8'h03;
    localparam logic [7:0] ADDR_SDM = 8'h04;
    localparam logic [7:0] ADDR_STS = 8'h05;
    localparam logic [7:0] ADDR_EVT = 8'h06;

    // ----------------------------------------------------------------
    // Reset values and writable-bit masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_LPF = 8'h76;
    localparam logic [7:0] RST_P3 = 8'h37;
    localparam logic [7:0] RST_LCK_LO = 8'h80;
    localparam logic [7:0] RST_LCK_HI = 8'h01;
    localparam logic [7:0] RST_SDM = 8'h03;
    localparam logic [7:0] MSK_LPF = 8'hFF;
    localparam logic [7:0] MSK_P3 = 8'hF7;
    localparam logic [7:0] MSK_LCK_LO = 8'hFF;
    localparam logic [7:0] MSK_LCK_HI = 8'h03;
    localparam logic [7:0] MSK_SDM = 8'h03;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ----------------------------------------------------------------
    // Field positions (filter and third-pole bypass bits, lock config low byte, high byte, status bits)
    // ----------------------------------------------------------------
    localparam int BIT_VCO_FBYP = 7;
    localparam int BIT_P3_BYP = 7;
    localparam int BIT_TIMER_HI = 7;
    localparam int BIT_TIMER_LO = 6;
    localparam int BIT_STICKY = 5;
    localparam int BIT_CAL_DET = 4;
    localparam int BIT_DET_DIS = 3;
    localparam int BIT_FINE_EN = 0;
    localparam int BIT_RAW_PIN = 1;
    localparam int BIT_LOCK_STS = 0;
    localparam int BIT_LOL = 0;

    // ----------------------------------------------------------------
    // Debounce timer codes and counter width
    // ----------------------------------------------------------------
    localparam logic [1:0] TMR_NONE = 2'h0;
    localparam logic [1:0] TMR_SHORT = 2'h1;
    localparam logic [1:0] TMR_MID = 2'h2;
    localparam int DEB_W = 16;

    // ----------------------------------------------------------------
    // Analog trim carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic vco_filter_bypass;
        logic [2:0] pole_cap_select;
        logic [3:0] zero_resistor_select;
        logic third_pole_bypass;
        logic [2:0] third_pole_res_select;
        logic [2:0] third_pole_cap_select;
        logic [2:0] lock_filter_res_select;
        logic fine_detect_enable;
        logic [1:0] feedback_modulator_order;
    } plk_trim_t;
endpackage

//--- rtl/plk_lock_cfg.sv
// PLL loop-filter configuration registers and digital lock qualification
`timescale 1ns/100ps

// Summary of operation
// - Debounce code 0 none, 1..3 are 570/5700/57000 cycles, reset code 2.
// - Sticky select holds lock once asserted; otherwise lock follows in real time.
// - Calibration-detect 0 gates detector until calibration done; 1 runs always.
// - Detector-disable forces lock asserted; otherwise normal detection applies.
// - Raw-to-pin bit drives the unqualified selected lock onto the status pin.
// - Fine-detect enable (reset 1) selects the threshold-based lock comparator.
// - Loop filter register: filter bypass, pole cap 6:4 reset 7, resistor 3:0 reset 6.
// - Third-pole register: resistor 6:4 reset 3, capacitor 2:0 reset 7, to trims.
// - Lock filter resistor select bits 2:0, reset 0, drives comparator trim.
// - Read-only status bit reads 1 while locked, 0 while unlocked.
// - Loss-of-lock flag sets on locked-to-unlocked; cleared by writing 1.
// - Two-bit modulator order: 0 integer, 1..3 first to third order.
module plk_lock_cfg #(
    parameter int DEB_CYC1 = 570,
    parameter int DEB_CYC2 = 5700,
    parameter int DEB_CYC3 = 57000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic csr_wr,
    input wire logic csr_rd,
    input wire logic [7:0] csr_addr,
    input wire logic [7:0] csr_wdata,
    output logic [7:0] csr_rdata,
    input wire logic raw_lock_fine,
    input wire logic raw_lock_orig,
    input wire logic vco_cal_done,
    output plk_pkg::plk_trim_t trim,
    output logic lock_qualified,
    output logic lock_pin
);
    import plk_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Masked byte write: reserved bits stay zero whatever is written
    function automatic logic [7:0] mwr(input logic [7:0] d, input logic [7:0] m);
        mwr = d & m;
    endfunction

    // Debounce length for a timer code
    function automatic logic [DEB_W-1:0] deb_limit(input logic [1:0] code);
        logic [DEB_W-1:0] r;
        r = DEB_W'(DEB_CYC3);
        if (code == TMR_NONE) begin
            r = '0;
        end else if (code == TMR_SHORT) begin
            r = DEB_W'(DEB_CYC1);
        end else if (code == TMR_MID) begin
            r = DEB_W'(DEB_CYC2);
        end
        deb_limit = r;
    endfunction

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] lpf_ff, p3_ff, lck_lo_ff, lck_hi_ff, sdm_ff, rdata_ff;
    logic lol_ff, lock_ff, pin_ff;
    logic [2:0] s1_ff, s2_ff;
    logic [DEB_W-1:0] cnt_ff, nxt_cnt;

    // Address decode
    wire logic wr_lpf = csr_wr && (csr_addr == ADDR_LPF);
    wire logic wr_p3 = csr_wr && (csr_addr == ADDR_P3);
    wire logic wr_lo = csr_wr && (csr_addr == ADDR_LCK_LO);
    wire logic wr_hi = csr_wr && (csr_addr == ADDR_LCK_HI);
    wire logic wr_sdm = csr_wr && (csr_addr == ADDR_SDM);
    wire logic wr_evt = csr_wr && (csr_addr == ADDR_EVT);

    // Config fields
    wire logic sticky = lck_lo_ff[BIT_STICKY];
    wire logic cal_det = lck_lo_ff[BIT_CAL_DET];
    wire logic det_dis = lck_lo_ff[BIT_DET_DIS];
    wire logic fine_en = lck_hi_ff[BIT_FINE_EN];
    wire logic raw_pin = lck_hi_ff[BIT_RAW_PIN];
    wire logic [1:0] tmr_code = lck_lo_ff[BIT_TIMER_HI:BIT_TIMER_LO];

    // Synchronised analog inputs: fine, original, calibration done
    wire logic fine_s = s2_ff[0];
    wire logic orig_s = s2_ff[1];
    wire logic cal_done_s = s2_ff[2];

    // ----------------------------------------------------------------
    // Lock qualification datapath
    // ----------------------------------------------------------------
    wire logic sel_raw = fine_en ? fine_s : orig_s;
    wire logic det_on = cal_det || cal_done_s;
    wire logic raw_eff = det_on && sel_raw;
    wire logic [DEB_W-1:0] limit = deb_limit(tmr_code);
    wire logic deb_ok = raw_eff && (cnt_ff >= limit);
    // Sticky keeps an asserted lock; detector disable overrides all
    wire logic nxt_lock = det_dis || deb_ok || (sticky && lock_ff);
    wire logic lol_set = lock_ff && !nxt_lock;
    wire logic evt_clr = wr_evt && csr_wdata[BIT_LOL];
    // Set beats a clear landing in the same cycle
    wire logic nxt_lol = lol_set || (lol_ff && !evt_clr);
    wire logic nxt_pin = raw_pin ? sel_raw : nxt_lock;

    // Counter restarts on raw drop and saturates at the limit
    always_comb begin
        nxt_cnt = cnt_ff;
        if (!raw_eff) begin
            nxt_cnt = '0;
        end else if (cnt_ff < limit) begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    // Read mux; unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = ZERO_BYTE;
        unique case (csr_addr)
            ADDR_LPF: rd_mux = lpf_ff;
            ADDR_P3: rd_mux = p3_ff;
            ADDR_LCK_LO: rd_mux = lck_lo_ff;
            ADDR_LCK_HI: rd_mux = lck_hi_ff;
            ADDR_SDM: rd_mux = sdm_ff;
            ADDR_STS: rd_mux[BIT_LOCK_STS] = lock_ff;
            ADDR_EVT: rd_mux[BIT_LOL] = lol_ff;
            default: rd_mux = ZERO_BYTE;
        endcase
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Reserved bits masked on every write so they always read zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lpf_ff <= RST_LPF;
            p3_ff <= RST_P3;
            lck_lo_ff <= RST_LCK_LO;
            lck_hi_ff <= RST_LCK_HI;
            sdm_ff <= RST_SDM;
        end else begin
            if (wr_lpf) lpf_ff <= mwr(csr_wdata, MSK_LPF);
            if (wr_p3) p3_ff <= mwr(csr_wdata, MSK_P3);
            if (wr_lo) lck_lo_ff <= mwr(csr_wdata, MSK_LCK_LO);
            if (wr_hi) lck_hi_ff <= mwr(csr_wdata, MSK_LCK_HI);
            if (wr_sdm) sdm_ff <= mwr(csr_wdata, MSK_SDM);
        end
    end

    // ----------------------------------------------------------------
    // Synchroniser, debounce and lock state
    // ----------------------------------------------------------------
    // Comparator outputs are asynchronous to clk, two stages each
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            cnt_ff <= '0;
            lock_ff <= 1'b0;
            lol_ff <= 1'b0;
            pin_ff <= 1'b0;
            rdata_ff <= ZERO_BYTE;
        end else begin
            s1_ff <= {vco_cal_done, raw_lock_orig, raw_lock_fine};
            s2_ff <= s1_ff;
            cnt_ff <= nxt_cnt;
            lock_ff <= nxt_lock;
            lol_ff <= nxt_lol;
            pin_ff <= nxt_pin;
            if (csr_rd) rdata_ff <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Trims come straight from the register flops
    assign trim.vco_filter_bypass = lpf_ff[BIT_VCO_FBYP];
    assign trim.pole_cap_select = lpf_ff[6:4];
    assign trim.zero_resistor_select = lpf_ff[3:0];
    // Bypass is only safe with an integer divider; software owns that
    assign trim.third_pole_bypass = p3_ff[BIT_P3_BYP];
    assign trim.third_pole_res_select = p3_ff[6:4];
    assign trim.third_pole_cap_select = p3_ff[2:0];
    assign trim.lock_filter_res_select = lck_lo_ff[2:0];
    assign trim.fine_detect_enable = fine_en;
    assign trim.feedback_modulator_order = sdm_ff[1:0];
    assign lock_qualified = lock_ff;
    assign lock_pin = pin_ff;
    assign csr_rdata = rdata_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Disabled detector must report lock on the next edge
    a_bypass_forces: assert property (@(posedge clk) disable iff (!resetn)
        det_dis |=> lock_ff)
        else $error("lock not forced while detector disabled");

    // A rise without the disable needs a full qualified interval
    a_rise_needs_raw: assert property (@(posedge clk) disable iff (!resetn)
        $rose(lock_ff) && !$past(det_dis) |-> $past(raw_eff) && $past(cnt_ff) >= $past(limit))
        else $error("lock rose before debounce interval");

    // Real-time mode drops one edge after the gated raw lock
    a_realtime_drop: assert property (@(posedge clk) disable iff (!resetn)
        !sticky && !det_dis && !raw_eff |=> !lock_ff)
        else $error("real-time lock did not follow raw drop");

    // One-time lock holds while software leaves the bit alone
    a_sticky_hold: assert property (@(posedge clk) disable iff (!resetn)
        sticky && lock_ff && !wr_lo |=> lock_ff)
        else $error("sticky lock released");

    // Any raw drop clears the interval count
    a_cnt_restart: assert property (@(posedge clk) disable iff (!resetn)
        !raw_eff |=> cnt_ff == '0)
        else $error("debounce counter not restarted");

    // Calibration gate keeps the counter idle
    a_cal_gate: assert property (@(posedge clk) disable iff (!resetn)
        !cal_det && !cal_done_s |-> !raw_eff ##1 cnt_ff == '0)
        else $error("detector ran during calibration");

    // Every fall of lock raises the loss-of-lock event
    a_lol_on_fall: assert property (@(posedge clk) disable iff (!resetn)
        $fell(lock_ff) |-> lol_ff)
        else $error("loss-of-lock flag not set");

    // Event flag only leaves on a write of one
    a_lol_sticky: assert property (@(posedge clk) disable iff (!resetn)
        lol_ff && !evt_clr |=> lol_ff)
        else $error("loss-of-lock flag cleared without write");

    // Raw mode shows the synced comparator one edge later
    a_pin_raw: assert property (@(posedge clk) disable iff (!resetn)
        raw_pin |=> pin_ff == $past(sel_raw))
        else $error("status pin not showing raw lock");

    // Status read returns the lock level of the read cycle
    a_sts_read: assert property (@(posedge clk) disable iff (!resetn)
        csr_rd && csr_addr == ADDR_STS |=> csr_rdata == {7'h00, $past(lock_ff)})
        else $error("status read mismatch");

    // Shortest code: the rise follows exactly that count
    a_short_timer: assert property (@(posedge clk) disable iff (!resetn)
        $rose(lock_ff) && $past(tmr_code == TMR_SHORT && !det_dis)
        |-> $past(cnt_ff) == DEB_W'(DEB_CYC1))
        else $error("short debounce length wrong");

    // Middle code: the rise follows exactly that count
    a_mid_timer: assert property (@(posedge clk) disable iff (!resetn)
        $rose(lock_ff) && $past(tmr_code == TMR_MID && !det_dis)
        |-> $past(cnt_ff) == DEB_W'(DEB_CYC2))
        else $error("middle debounce length wrong");

    // Longest code: the rise follows exactly that count
    a_long_timer: assert property (@(posedge clk) disable iff (!resetn)
        $rose(lock_ff) && $past(!det_dis && tmr_code != TMR_NONE && tmr_code != TMR_SHORT
        && tmr_code != TMR_MID) |-> $past(cnt_ff) == DEB_W'(DEB_CYC3))
        else $error("long debounce length wrong");

    // Code zero qualifies on the first gated raw edge
    a_zero_timer: assert property (@(posedge clk) disable iff (!resetn)
        tmr_code == TMR_NONE && raw_eff |=> lock_ff)
        else $error("zero debounce code delayed lock");

    // Detector set wins over a clear in the same cycle
    a_lol_set_wins: assert property (@(posedge clk) disable iff (!resetn)
        lol_set |=> lol_ff)
        else $error("loss-of-lock set lost to a clear");

    // A write of one with no new loss clears the flag
    a_lol_clear: assert property (@(posedge clk) disable iff (!resetn)
        evt_clr && !lol_set |=> !lol_ff)
        else $error("loss-of-lock flag not cleared");

    // Event read returns the flag of the read cycle
    a_evt_read: assert property (@(posedge clk) disable iff (!resetn)
        csr_rd && csr_addr == ADDR_EVT |=> csr_rdata[BIT_LOL] == $past(lol_ff))
        else $error("event read mismatch");

    // Qualified mode: the pin mirrors the qualified lock
    a_pin_qual: assert property (@(posedge clk) disable iff (!resetn)
        !raw_pin |=> pin_ff == lock_ff)
        else $error("status pin not showing qualified lock");

    // Precision comparator feeds the pin when enabled
    a_fine_select: assert property (@(posedge clk) disable iff (!resetn)
        fine_en && raw_pin |=> pin_ff == $past(fine_s))
        else $error("precision comparator not selected");

    // Original comparator feeds it otherwise
    a_orig_select: assert property (@(posedge clk) disable iff (!resetn)
        !fine_en && raw_pin |=> pin_ff == $past(orig_s))
        else $error("original comparator not selected");

    // Reserved bits never hold a one
    a_rsvd_zero: assert property (@(posedge clk) disable iff (!resetn)
        (p3_ff & ~MSK_P3) == ZERO_BYTE && (lck_hi_ff & ~MSK_LCK_HI) == ZERO_BYTE
        && (sdm_ff & ~MSK_SDM) == ZERO_BYTE)
        else $error("reserved register bit set");

    // Read data stands until the next read
    a_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
        !csr_rd |=> $stable(csr_rdata))
        else $error("read data changed without a read");

    // Loop-filter write lands whole on the next edge
    a_lpf_write: assert property (@(posedge clk) disable iff (!resetn)
        wr_lpf |=> lpf_ff == $past(csr_wdata & MSK_LPF))
        else $error("loop filter write lost");
endmodule

//--- dv/plk_pll_model.sv
// Behavioural model of the analog PLL core and its two lock comparators
`timescale 1ns/100ps
module plk_pll_model (
    input wire logic clk,
    input wire logic want_fine,
    input wire logic want_orig,
    input wire logic want_cal,
    output logic raw_lock_fine,
    output logic raw_lock_orig,
    output logic vco_cal_done
);
    logic hold_fine, hold_orig, hold_cal;
    // Wishes taken on the rising edge, so a falling-edge bench change never races
    always @(posedge clk) begin
        hold_fine <= want_fine;
        hold_orig <= want_orig;
        hold_cal <= want_cal;
    end
    // Analog levels move away from the design's sampling edge
    always @(negedge clk) begin
        raw_lock_fine <= hold_fine;
        raw_lock_orig <= hold_orig;
        vco_cal_done <= hold_cal;
    end
endmodule

//--- dv/tb.sv
// Self-checking testbench of the PLL lock configuration block
`timescale 1ns/100ps
module tb;
    import plk_pkg::*;
    logic clk, resetn, csr_wr, csr_rd, want_fine, want_orig, want_cal;
    logic [7:0] csr_addr, csr_wdata, csr_rdata, v;
    logic raw_lock_fine, raw_lock_orig, vco_cal_done, lock_qualified, lock_pin;
    plk_trim_t trim;
    int failures, n_checks, n;
    // Shortened debounce limits keep the run brief
    localparam int LIM [4] = '{0, 5, 10, 20};
    plk_lock_cfg #(.DEB_CYC1(5), .DEB_CYC2(10), .DEB_CYC3(20)) i_plk_lock_cfg (
        .clk(clk), .resetn(resetn), .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_addr(csr_addr),
        .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .raw_lock_fine(raw_lock_fine),
        .raw_lock_orig(raw_lock_orig), .vco_cal_done(vco_cal_done), .trim(trim),
        .lock_qualified(lock_qualified), .lock_pin(lock_pin));
    plk_pll_model i_plk_pll_model (.clk(clk), .want_fine(want_fine), .want_orig(want_orig),
        .want_cal(want_cal), .raw_lock_fine(raw_lock_fine), .raw_lock_orig(raw_lock_orig),
        .vco_cal_done(vco_cal_done));
    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // One-cycle strobes launched on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        csr_wr = 1'b1;
        csr_addr = a;
        csr_wdata = d;
        @(negedge clk);
        csr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        csr_rd = 1'b1;
        csr_addr = a;
        @(negedge clk);
        csr_rd = 1'b0;
        @(negedge clk);
        d = csr_rdata;
    endtask
    // Bounded wait on the qualified lock level
    task automatic wq(input logic val, input int lim);
        n = 0;
        while (lock_qualified !== val && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] rv [5];
        rv = '{RST_LPF, RST_P3, RST_LCK_LO, RST_LCK_HI, RST_SDM};
        chk(32'(trim), 32'({RST_LPF, RST_P3[7:4], RST_P3[2:0], RST_LCK_LO[2:0],
            RST_LCK_HI[BIT_FINE_EN], RST_SDM[1:0]}));
        for (int a = 0; a < 5; a++) begin
            rd(8'(a), v);
            chk(v, rv[a]);
        end
        $display("test reset values done");
    endtask
    task automatic t_regs();
        logic [7:0] mk [5];
        mk = '{MSK_LPF, MSK_P3, MSK_LCK_LO, MSK_LCK_HI, MSK_SDM};
        // Counting down leaves the integer divider selected
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_SDM, 8'(3 - c));
            chk(trim.feedback_modulator_order, 3 - c);
        end
        wr(ADDR_STS, 8'hFF);
        rd(ADDR_STS, v);
        chk(v, 8'h00);
        wr(8'h07, 8'hFF);
        rd(8'h07, v);
        chk(v, 8'h00);
        // Modulator order is 0 here, so setting the third-pole bypass is legal
        for (int a = 0; a < 4; a++) begin
            wr(8'(a), 8'hFF);
            rd(8'(a), v);
            chk(v, mk[a]);
        end
        chk(32'(trim), 32'h1FFFFC);
        // Bypass goes back off before the modulator leaves integer mode
        wr(ADDR_P3, RST_P3);
        wr(ADDR_SDM, 8'hFF);
        rd(ADDR_SDM, v);
        chk(v, mk[4]);
        wr(ADDR_LCK_LO, 8'h00);
        wr(ADDR_LCK_HI, 8'h01);
        wr(ADDR_SDM, 8'h00);
        $display("test register access done");
    endtask
    task automatic t_debounce();
        want_cal = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_LCK_LO, 8'(c << 6));
            want_fine = 1'b0;
            cyc(8);
            want_fine = 1'b1;
            wq(1'b1, LIM[c] + 10);
            chk(n >= LIM[c] + 2 && n <= LIM[c] + 6, 1);
            chk(lock_pin, 1'b1);
        end
        // A short drop mid-count must restart the interval
        wr(ADDR_LCK_LO, 8'h40);
        want_fine = 1'b0;
        cyc(8);
        want_fine = 1'b1;
        cyc(3);
        want_fine = 1'b0;
        cyc(1);
        want_fine = 1'b1;
        wq(1'b1, 20);
        chk(n >= LIM[1] + 2 && n <= LIM[1] + 6, 1);
        $display("test debounce done");
    endtask
    task automatic t_sticky();
        wr(ADDR_EVT, 8'h01);
        wr(ADDR_LCK_LO, 8'h20);
        cyc(10);
        want_fine = 1'b0;
        cyc(10);
        chk(lock_qualified, 1'b1);
        wr(ADDR_LCK_LO, 8'h00);
        wq(1'b0, 10);
        chk(lock_qualified, 1'b0);
        want_fine = 1'b1;
        wq(1'b1, 10);
        rd(ADDR_STS, v);
        chk(v, 8'h01);
        want_fine = 1'b0;
        wq(1'b0, 10);
        chk(n <= 6, 1);
        rd(ADDR_STS, v);
        chk(v, 8'h00);
        rd(ADDR_EVT, v);
        chk(v, 8'h01);
        wr(ADDR_EVT, 8'h01);
        rd(ADDR_EVT, v);
        chk(v, 8'h00);
        $display("test sticky and event done");
    endtask
    task automatic t_cal_dis();
        want_cal = 1'b0;
        want_fine = 1'b1;
        cyc(20);
        chk(lock_qualified, 1'b0);
        want_cal = 1'b1;
        wq(1'b1, 10);
        chk(lock_qualified, 1'b1);
        want_cal = 1'b0;
        want_fine = 1'b0;
        cyc(8);
        wr(ADDR_LCK_LO, 8'h10);
        want_fine = 1'b1;
        wq(1'b1, 10);
        chk(lock_qualified, 1'b1);
        want_fine = 1'b0;
        wr(ADDR_LCK_LO, 8'h08);
        cyc(8);
        chk(lock_qualified, 1'b1);
        $display("test calibration and disable done");
    endtask
    task automatic t_rawpin();
        wr(ADDR_LCK_LO, 8'hD0);
        wr(ADDR_LCK_HI, 8'h03);
        want_fine = 1'b1;
        cyc(6);
        chk({lock_pin, lock_qualified}, 2'b10);
        wr(ADDR_LCK_HI, 8'h02);
        cyc(4);
        chk(lock_pin, 1'b0);
        want_orig = 1'b1;
        cyc(5);
        chk(lock_pin, 1'b1);
        $display("test raw lock to pin done");
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Main sequence after a 12-cycle reset
    initial begin
        {resetn, csr_wr, csr_rd, want_fine, want_orig, want_cal} = '0;
        {csr_addr, csr_wdata, failures, n_checks} = '0;
        cyc(12);
        resetn = 1'b1;
        t_reset();
        t_regs();
        t_debounce();
        t_sticky();
        t_cal_dis();
        t_rawpin();
        summarize();
    end
    // Watchdog well beyond the expected run of about 320 cycles
    initial begin
        #40000;
        failures++;
        summarize();
    end
endmodule
